// File: core/uic_ctrl.sv
// Interrupt priority, line format and modem control for one uart channel
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module uic_ctrl
    import uic_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Event inputs from the data path, same clock
    input wire logic i_line_err,
    input wire logic i_rx_avail,
    input wire logic i_rx_timeout,
    input wire logic i_tx_empty,
    input wire logic i_special_char,
    input wire logic i_xoff_rcvd,
    input wire logic i_xon_rcvd,
    input wire logic [7:0] i_line_status,
    input wire logic [7:0] i_rx_data,
    // Modem pins, asynchronous
    input wire logic i_cts_n,
    input wire logic i_dsr_n,
    input wire logic i_ri_n,
    input wire logic i_cd_n,
    // Transmit serial data from the shift register
    input wire logic i_tx_shift,
    // Interface to data path
    output logic o_tx_wr,
    output logic [7:0] o_tx_data,
    output logic o_rx_rd,
    output logic [1:0] o_char_len,
    output logic [3:0] o_data_bits,
    output logic [1:0] o_stop_halves,
    output logic o_rx_stop_one,
    output logic o_parity_en,
    output logic o_parity_even,
    output logic o_parity_force,
    output logic o_parity_force_val,
    output logic [15:0] o_divisor,
    output logic o_loopback,
    output logic o_xon_any,
    output logic o_ir_en,
    // Pins
    output logic o_txd,
    output logic o_dtr_n,
    output logic o_rts_n,
    output logic o_irq,
    output logic o_irq_oe
);

    // Software visible registers
    logic [7:0] lfc_r;       // Line format control
    logic [7:0] moc_r;       // Modem output control
    logic [7:0] ier_r;       // Interrupt enable
    logic [7:0] efr_r;       // Enhanced features
    logic [15:0] dl_r;       // Baud divisor latches
    // Sticky sources and state
    logic tx_pend_r;         // Transmit empty pending
    logic sc_pend_r;         // Special character pending
    logic xoff_pend_r;       // Xoff pending until Xon, or until rx data with Xany enabled
    logic ms_pend_r;         // Modem line change pending
    logic fc_pend_r;         // CTS/RTS change pending
    logic tx_empty_d_r;      // Edge detect of transmit empty
    // Modem input synchronisers
    logic [3:0] mdm_s1_r;
    logic [3:0] mdm_s2_r;
    logic [3:0] mdm_prev_r;
    logic [3:0] mdm_delta_r; // Modem status delta bits
    logic rts_prev_r;
    // Decode helpers
    logic dls;
    logic locked;
    logic enh;
    logic wr_data;
    logic rd_data;
    logic rd_isr;
    logic rd_lsr;
    logic rd_msr;
    logic [3:0] mdm_eff;     // Effective active-high cts, dsr, ri, cd
    logic [5:0] isr_code;
    logic [7:0] rdata_nxt;

    assign dls = lfc_r[UIC_LFC_DLS];
    assign locked = (lfc_r == UIC_LFC_LOCK);
    assign enh = efr_r[UIC_EFR_ENH];
    // Data port goes to the holding registers only outside divisor access
    assign wr_data = i_wr && i_addr == UIC_OFF_DATA
        && !dls && !locked;
    assign rd_data = i_rd && i_addr == UIC_OFF_DATA
        && !dls && !locked;
    assign rd_isr = i_rd && i_addr == UIC_OFF_ISR && !locked;
    assign rd_lsr = i_rd && i_addr == UIC_OFF_LSR && !locked;
    assign rd_msr = i_rd && i_addr == UIC_OFF_MSR && !locked;

    // Line format control, writable at any time
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            lfc_r <= UIC_LFC_RST;
        else if (i_wr && i_addr == UIC_OFF_LFC)
            lfc_r <= i_wdata;
    end

    // Modem control, shut out while the lock value is present
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            moc_r <= UIC_MOC_RST;
        else if (i_wr && i_addr == UIC_OFF_MOC && !locked)
            moc_r <= i_wdata;
    end

    // Enhanced features only reachable behind the lock value
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            efr_r <= UIC_EFR_RST;
        else if (i_wr && i_addr == UIC_OFF_EFR && locked)
            efr_r <= i_wdata;
    end

    // Divisor latches and interrupt enable share offsets 0 and 1
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            dl_r <= {UIC_DL_RST, UIC_DL_RST};
            ier_r <= UIC_IER_RST;
        end
        else if (i_wr && !locked)
        begin
            if (dls && i_addr == UIC_OFF_DATA)
                dl_r[7:0] <= i_wdata;
            else if (dls && i_addr == UIC_OFF_IER)
                dl_r[15:8] <= i_wdata;
            else if (!dls && i_addr == UIC_OFF_IER)
                ier_r <= i_wdata;
        end
    end

    // Modem pins pass two flops before use
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            mdm_s1_r <= 4'h0;
            mdm_s2_r <= 4'h0;
        end
        else
        begin
            mdm_s1_r <= {~i_cd_n, ~i_ri_n, ~i_dsr_n, ~i_cts_n};
            mdm_s2_r <= mdm_s1_r;
        end
    end

    // Loopback feeds modem outputs back in place of the pins
    always_comb
    begin
        if (moc_r[UIC_MOC_LOOP])
        begin
            mdm_eff[0] = moc_r[UIC_MOC_RTS];
            mdm_eff[1] = moc_r[UIC_MOC_DTR];
            mdm_eff[2] = moc_r[UIC_MOC_AUX1];
            mdm_eff[3] = moc_r[UIC_MOC_AUX2];
        end
        else
        begin
            mdm_eff = mdm_s2_r;
        end
    end

    // Modem delta bits; a change in the same cycle as the read wins
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            mdm_prev_r <= 4'h0;
            mdm_delta_r <= 4'h0;
            ms_pend_r <= 1'b0;
            fc_pend_r <= 1'b0;
            rts_prev_r <= 1'b0;
        end
        else
        begin
            mdm_prev_r <= mdm_eff;
            rts_prev_r <= moc_r[UIC_MOC_RTS];
            mdm_delta_r <= (rd_msr ? 4'h0 : mdm_delta_r)
                | (mdm_eff ^ mdm_prev_r);
            if (mdm_eff != mdm_prev_r)
                ms_pend_r <= 1'b1;
            else if (rd_msr)
                ms_pend_r <= 1'b0;
            if (mdm_eff[0] != mdm_prev_r[0]
                || moc_r[UIC_MOC_RTS] != rts_prev_r)
                fc_pend_r <= 1'b1;
            else if (rd_msr)
                fc_pend_r <= 1'b0;
        end
    end

    // Transmit empty: set on the rising edge of empty
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            tx_empty_d_r <= 1'b0;
            tx_pend_r <= 1'b0;
        end
        else
        begin
            tx_empty_d_r <= i_tx_empty;
            if (i_tx_empty && !tx_empty_d_r)
                tx_pend_r <= 1'b1;
            // A read that shows this code, or a data write, clears it
            else if ((rd_isr && isr_code == UIC_ISR_TX) || wr_data)
                tx_pend_r <= 1'b0;
        end
    end

    // Special character and Xoff flags
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            sc_pend_r <= 1'b0;
            xoff_pend_r <= 1'b0;
        end
        else
        begin
            if (i_special_char)
                sc_pend_r <= 1'b1;
            // A status read showing a higher source leaves this pending
            else if (rd_isr && isr_code == UIC_ISR_SC)
                sc_pend_r <= 1'b0;
            if (i_xoff_rcvd)
                xoff_pend_r <= 1'b1;
            else if (i_xon_rcvd || (moc_r[UIC_MOC_XANY] && enh
                     && i_rx_avail))
                xoff_pend_r <= 1'b0;
        end
    end

    // Priority encoder; line error, rx data and time-out are live levels
    // from the data path, which drops them when the reads below occur
    always_comb
    begin
        if (ier_r[UIC_IER_LS] && i_line_err)
            isr_code = UIC_ISR_LS;
        else if (ier_r[UIC_IER_RX] && i_rx_timeout)
            isr_code = UIC_ISR_TO;
        else if (ier_r[UIC_IER_RX] && i_rx_avail)
            isr_code = UIC_ISR_RX;
        else if (ier_r[UIC_IER_TX] && tx_pend_r)
            isr_code = UIC_ISR_TX;
        else if (ier_r[UIC_IER_MS] && ms_pend_r)
            isr_code = UIC_ISR_MS;
        else if (ier_r[UIC_IER_SC] && (sc_pend_r || xoff_pend_r))
            isr_code = UIC_ISR_SC;
        else if (ier_r[UIC_IER_FC] && fc_pend_r)
            isr_code = UIC_ISR_FC;
        else
            isr_code = UIC_ISR_NONE;
    end

    // Read mux
    always_comb
    begin
        rdata_nxt = 8'h00;
        case (i_addr)
            UIC_OFF_DATA:
                rdata_nxt = locked ? 8'h00 : (dls ? dl_r[7:0] : i_rx_data);
            UIC_OFF_IER:
                rdata_nxt = locked ? 8'h00 : (dls ? dl_r[15:8] : ier_r);
            UIC_OFF_ISR:
                rdata_nxt = locked ? 8'h00 : {2'b00, isr_code};
            UIC_OFF_LFC:
                rdata_nxt = lfc_r;
            UIC_OFF_MOC:
                rdata_nxt = locked ? 8'h00 : moc_r;
            UIC_OFF_LSR:
                rdata_nxt = locked ? 8'h00 : i_line_status;
            UIC_OFF_MSR:
                rdata_nxt = locked ? 8'h00 : {mdm_eff, mdm_delta_r};
            UIC_OFF_EFR:
                rdata_nxt = locked ? efr_r : 8'h00;
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    // Read data registered, valid the cycle after the strobe only
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= rdata_nxt;
        else
            o_rdata <= 8'h00;
    end

    // Strobes to the data path; holding register write and receive data read
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_tx_wr <= 1'b0;
            o_tx_data <= 8'h00;
            o_rx_rd <= 1'b0;
        end
        else
        begin
            o_tx_wr <= wr_data;
            if (wr_data)
                o_tx_data <= i_wdata;
            o_rx_rd <= rd_data;
        end
    end

    // Frame format to transmitter and receiver
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_char_len <= 2'b00;
            o_data_bits <= 4'h5;
            o_stop_halves <= UIC_STOP_HALVES_1;
            o_rx_stop_one <= 1'b1;
            o_parity_en <= 1'b0;
            o_parity_even <= 1'b0;
            o_parity_force <= 1'b0;
            o_parity_force_val <= 1'b1;
            o_divisor <= {UIC_DL_RST, UIC_DL_RST};
        end
        else
        begin
            o_char_len <= lfc_r[1:0];
            o_data_bits <= 4'h5 + {2'b00, lfc_r[1:0]};
            if (!lfc_r[UIC_LFC_STOP])
                o_stop_halves <= UIC_STOP_HALVES_1;
            else if (lfc_r[1:0] == 2'b00)
                o_stop_halves <= UIC_STOP_HALVES_15;
            else
                o_stop_halves <= 2'h0; // Zero encodes two full bits
            o_rx_stop_one <= 1'b1;
            o_parity_en <= lfc_r[UIC_LFC_PEN];
            o_parity_even <= lfc_r[UIC_LFC_PSEL];
            o_parity_force <= lfc_r[UIC_LFC_PEN] && lfc_r[UIC_LFC_FORCE];
            o_parity_force_val <= ~lfc_r[UIC_LFC_PSEL];
            o_divisor <= dl_r;
        end
    end

    // Modem and mode outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_txd <= 1'b1;
            o_dtr_n <= 1'b1;
            o_rts_n <= 1'b1;
            o_loopback <= 1'b0;
            o_xon_any <= 1'b0;
            o_ir_en <= 1'b0;
            o_irq <= 1'b0;
            o_irq_oe <= 1'b0;
        end
        else
        begin
            // Break wins over loopback and the shift register; without break the pin idles in loopback
            if (lfc_r[UIC_LFC_BRK])
                o_txd <= 1'b0;
            else if (moc_r[UIC_MOC_LOOP])
                o_txd <= 1'b1;
            else
                o_txd <= i_tx_shift;
            // Modem lines inactive on the pins during loopback
            o_dtr_n <= moc_r[UIC_MOC_LOOP] | ~moc_r[UIC_MOC_DTR];
            o_rts_n <= moc_r[UIC_MOC_LOOP] | ~moc_r[UIC_MOC_RTS];
            o_loopback <= moc_r[UIC_MOC_LOOP];
            o_xon_any <= enh && moc_r[UIC_MOC_XANY];
            o_ir_en <= enh && moc_r[UIC_MOC_IR];
            o_irq <= (isr_code != UIC_ISR_NONE);
            o_irq_oe <= moc_r[UIC_MOC_AUX2];
        end
    end

endmodule
`default_nettype wire

// File: core/uic_pkg.sv
// Package of register offsets, fields and codes for the uart control block
package uic_pkg;
    // Register offsets (3-bit register address)
    localparam logic [2:0] UIC_OFF_DATA = 3'h0;
    localparam logic [2:0] UIC_OFF_IER = 3'h1;
    localparam logic [2:0] UIC_OFF_ISR = 3'h2;
    localparam logic [2:0] UIC_OFF_LFC = 3'h3;
    localparam logic [2:0] UIC_OFF_MOC = 3'h4;
    localparam logic [2:0] UIC_OFF_LSR = 3'h5;
    localparam logic [2:0] UIC_OFF_MSR = 3'h6;
    localparam logic [2:0] UIC_OFF_EFR = 3'h7;
    // Reset values
    localparam logic [7:0] UIC_LFC_RST = 8'h00;
    localparam logic [7:0] UIC_MOC_RST = 8'h00;
    localparam logic [7:0] UIC_IER_RST = 8'h00;
    localparam logic [7:0] UIC_DL_RST = 8'h00;
    localparam logic [7:0] UIC_EFR_RST = 8'h00;
    // Line control value that locks out the modem control register
    localparam logic [7:0] UIC_LFC_LOCK = 8'hBF;
    // Line control fields
    localparam int UIC_LFC_STOP = 2;
    localparam int UIC_LFC_PEN = 3;
    localparam int UIC_LFC_PSEL = 4;
    localparam int UIC_LFC_FORCE = 5;
    localparam int UIC_LFC_BRK = 6;
    localparam int UIC_LFC_DLS = 7;
    // Modem control fields
    localparam int UIC_MOC_DTR = 0;
    localparam int UIC_MOC_RTS = 1;
    localparam int UIC_MOC_AUX1 = 2;
    localparam int UIC_MOC_AUX2 = 3;
    localparam int UIC_MOC_LOOP = 4;
    localparam int UIC_MOC_XANY = 5;
    localparam int UIC_MOC_IR = 6;
    // Enhanced feature enable bit
    localparam int UIC_EFR_ENH = 4;
    // Interrupt enable fields
    localparam int UIC_IER_RX = 0;
    localparam int UIC_IER_TX = 1;
    localparam int UIC_IER_LS = 2;
    localparam int UIC_IER_MS = 3;
    localparam int UIC_IER_SC = 5;
    localparam int UIC_IER_FC = 7;
    // Interrupt codes in bits 5..0 of interrupt status
    localparam logic [5:0] UIC_ISR_NONE = 6'h01;
    localparam logic [5:0] UIC_ISR_LS = 6'h06;
    localparam logic [5:0] UIC_ISR_RX = 6'h04;
    localparam logic [5:0] UIC_ISR_TO = 6'h0C;
    localparam logic [5:0] UIC_ISR_TX = 6'h02;
    localparam logic [5:0] UIC_ISR_MS = 6'h00;
    localparam logic [5:0] UIC_ISR_SC = 6'h10;
    localparam logic [5:0] UIC_ISR_FC = 6'h20;
    // Frame format codes: stop length in half bits
    localparam logic [1:0] UIC_STOP_HALVES_1 = 2'h2;
    localparam logic [1:0] UIC_STOP_HALVES_15 = 2'h3;
endpackage

// File: test/uic_ctrl_sva.sv
// Checker of format, pin and bus relations for the uart control block
`timescale 1ns/1ps
`default_nettype none
module uic_ctrl_chk
    import uic_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_tx_wr,
    input wire logic [7:0] o_tx_data,
    input wire logic [3:0] o_data_bits,
    input wire logic [1:0] o_stop_halves,
    input wire logic o_txd,
    input wire logic o_dtr_n,
    input wire logic o_rts_n,
    input wire logic o_irq_oe
);
    logic [7:0] lfc_r; // Mirror of line control
    logic [7:0] moc_r; // Mirror of modem control
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Mirrors follow the bus; a locked modem write is dropped
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            lfc_r <= UIC_LFC_RST;
            moc_r <= UIC_MOC_RST;
        end
        else if (i_wr && i_addr == UIC_OFF_LFC)
            lfc_r <= i_wdata;
        else if (i_wr && i_addr == UIC_OFF_MOC && lfc_r != UIC_LFC_LOCK)
            moc_r <= i_wdata;
    end
    a_char_len:
        assert property (1 |=> o_data_bits
            == 4'h5 + {2'b00, $past(lfc_r[1:0])})
        else $error("Data bit count wrong");
    a_stop_len:
        assert property (1 |=> o_stop_halves == (!$past(lfc_r[UIC_LFC_STOP])
            ? UIC_STOP_HALVES_1 : ($past(lfc_r[1:0]) == 2'h0
            ? UIC_STOP_HALVES_15 : 2'h0)))
        else $error("Stop length wrong");
    a_break_low:
        assert property (lfc_r[UIC_LFC_BRK] |=> !o_txd)
        else $error("Break does not hold line low");
    a_loop_idle:
        assert property (moc_r[UIC_MOC_LOOP] && !lfc_r[UIC_LFC_BRK]
            |=> o_txd && o_dtr_n && o_rts_n)
        else $error("Loopback leaks to pins");
    a_modem_inv:
        assert property (!moc_r[UIC_MOC_LOOP] |=> o_dtr_n == !$past(moc_r[0])
            && o_rts_n == !$past(moc_r[1]))
        else $error("Modem outputs not inverted");
    a_lock_read:
        assert property (i_rd && i_addr == UIC_OFF_MOC
            && lfc_r == UIC_LFC_LOCK |=> o_rdata == 8'h00)
        else $error("Locked modem control readable");
    a_irq_drive:
        assert property (1 |=> o_irq_oe == $past(moc_r[UIC_MOC_AUX2]))
        else $error("Irq enable not following aux two");
    a_tx_write:
        assert property (i_wr && i_addr == UIC_OFF_DATA && !lfc_r[UIC_LFC_DLS]
            |=> o_tx_wr && o_tx_data == $past(i_wdata))
        else $error("Data write not passed on");
    c_locked: cover property (lfc_r == UIC_LFC_LOCK && i_rd);
    c_loop: cover property (moc_r[UIC_MOC_LOOP] && o_txd);
    c_txwr: cover property (o_tx_wr);
endmodule
bind uic_ctrl uic_ctrl_chk u_chk (.*);
`default_nettype wire

// File: test/uic_ctrl_tb.sv
// Self-checking bench of the uart control block
`timescale 1ns/1ps
`default_nettype none
module uic_ctrl_tb
    import uic_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr, i_rd, i_tx_shift;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, i_line_status, i_rx_data, o_tx_data;
    logic i_line_err, i_rx_avail, i_rx_timeout, i_tx_empty, i_special_char;
    logic i_xoff_rcvd, i_xon_rcvd, i_cts_n, i_dsr_n, i_ri_n, i_cd_n;
    logic o_tx_wr, o_rx_rd, o_rx_stop_one, o_parity_en, o_parity_even;
    logic o_parity_force, o_parity_force_val, o_loopback, o_xon_any, o_ir_en;
    logic o_txd, o_dtr_n, o_rts_n, o_irq, o_irq_oe;
    logic [1:0] o_char_len, o_stop_halves;
    logic [3:0] o_data_bits;
    logic [15:0] o_divisor;
    logic [7:0] rv, lv, mv; // Read value, line and modem settings
    int errors = 0;
    int comparisons = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    // Serial source takes a new random bit every cycle so stale bits show
    always @(posedge i_clk_sys) i_tx_shift <= 1'($urandom);
    uic_ctrl dut (.*);
    uic_host host (.i_clk_sys(i_clk_sys), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata));
    task automatic chk(input string n, input logic [7:0] s,
        input logic [7:0] e);
        comparisons++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("Comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic interrupt_status_reg(input logic [5:0] c);
        host.rd(UIC_OFF_ISR, rv);
        chk("isr", rv, {2'b00, c});
    endtask
    function automatic logic [1:0] exp_stop(input logic [7:0] l);
        if (!l[UIC_LFC_STOP])
            return UIC_STOP_HALVES_1;
        return (l[1:0] == 2'h0) ? UIC_STOP_HALVES_15 : 2'h0;
    endfunction
    // Hang guard
    initial
    begin
        #200000;
        errors++;
        results();
    end
    initial
    begin
        {i_line_err, i_rx_avail, i_rx_timeout, i_tx_empty} = '0;
        {i_special_char, i_xoff_rcvd, i_xon_rcvd} = '0;
        {i_cts_n, i_dsr_n, i_ri_n, i_cd_n} = '1;
        void'($urandom(32'hd906_c956));
        {i_line_status, i_rx_data} = 16'($urandom);
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        host.rd(UIC_OFF_MOC, rv);
        chk("moc rst", rv, UIC_MOC_RST);
        interrupt_status_reg(UIC_ISR_NONE);
        // Random line formats, every length code first
        for (int k = 0; k < 16; k++)
        begin
            lv = 8'($urandom) & 8'h7F;
            if (k < 4)
                lv[1:0] = k[1:0];
            host.wr(UIC_OFF_LFC, lv);
            host.rd(UIC_OFF_LFC, rv);
            chk("lfc", rv, lv);
            chk("bits", 8'(o_data_bits), 8'(4'h5 + lv[1:0]));
            chk("len", 8'(o_char_len), 8'(lv[1:0]));
            chk("stop", 8'(o_stop_halves), 8'(exp_stop(lv)));
            chk("rxstop", 8'(o_rx_stop_one), 8'h01);
            chk("pen", 8'(o_parity_en), 8'(lv[3]));
            chk("peven", 8'(o_parity_even), 8'(lv[4]));
            chk("pfrc", 8'({o_parity_force, o_parity_force_val}),
                8'({lv[3] & lv[5], ~lv[4]}));
            if (lv[UIC_LFC_BRK])
                chk("txd", 8'(o_txd), 8'h00);
        end
        $display("Test format done");
        host.wr(UIC_OFF_LFC, 8'h03);
        for (int k = 0; k < 16; k++)
        begin
            mv = 8'($urandom) & 8'h1F;
            host.wr(UIC_OFF_MOC, mv);
            host.rd(UIC_OFF_MOC, rv);
            chk("moc", rv, mv);
            chk("pins", 8'({o_dtr_n, o_rts_n}),
                mv[4] ? 8'h03 : 8'({~mv[0], ~mv[1]}));
            chk("oe", 8'(o_irq_oe), 8'(mv[3]));
            chk("loop", 8'(o_loopback), 8'(mv[4]));
            host.rd(UIC_OFF_MSR, rv);
            if (mv[4])
                chk("msr", 8'(rv[7:4]),
                    8'({mv[3:2], mv[0], mv[1]}));
            else
                chk("msr pins", 8'(rv[7:4]), 8'h00);
        end
        $display("Test modem done");
        host.wr(UIC_OFF_LFC, UIC_LFC_LOCK);
        host.wr(UIC_OFF_MOC, 8'h0F);
        host.rd(UIC_OFF_MOC, rv);
        chk("moc lock", rv, 8'h00);
        host.wr(UIC_OFF_EFR, 8'h10);
        host.wr(UIC_OFF_LFC, 8'h03);
        host.rd(UIC_OFF_MOC, rv);
        chk("moc kept", rv, mv);
        host.rd(UIC_OFF_EFR, rv);
        chk("efr hidden", rv, 8'h00);
        host.wr(UIC_OFF_MOC, 8'h60);
        host.rd(UIC_OFF_MOC, rv);
        chk("enh on", 8'({o_xon_any, o_ir_en}), 8'h03);
        host.wr(UIC_OFF_LFC, UIC_LFC_LOCK);
        host.wr(UIC_OFF_EFR, 8'h00);
        host.wr(UIC_OFF_LFC, 8'h83);
        chk("enh off", 8'({o_xon_any, o_ir_en}), 8'h00);
        lv = 8'($urandom);
        host.wr(UIC_OFF_DATA, lv);
        host.wr(UIC_OFF_IER, ~lv);
        host.wr(UIC_OFF_LFC, 8'h03);
        chk("div lo", o_divisor[7:0], lv);
        chk("div hi", o_divisor[15:8], ~lv);
        $display("Test lock done");
        // All sources at once, then peeled off in priority order
        host.wr(UIC_OFF_IER, 8'hAF);
        @(posedge i_clk_sys) {i_line_err, i_rx_avail, i_rx_timeout} <= 3'h7;
        @(posedge i_clk_sys) {i_tx_empty, i_special_char, i_cts_n} <= 3'h6;
        @(posedge i_clk_sys) i_special_char <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        interrupt_status_reg(UIC_ISR_LS);
        host.rd(UIC_OFF_LSR, rv);
        chk("lsr", rv, i_line_status);
        @(posedge i_clk_sys) i_line_err <= 1'b0;
        interrupt_status_reg(UIC_ISR_TO);
        @(posedge i_clk_sys) i_rx_timeout <= 1'b0;
        interrupt_status_reg(UIC_ISR_RX);
        host.rd(UIC_OFF_DATA, rv);
        chk("rhr", rv, i_rx_data);
        chk("rxrd", 8'(o_rx_rd), 8'h01);
        @(posedge i_clk_sys) i_rx_avail <= 1'b0;
        interrupt_status_reg(UIC_ISR_TX);
        interrupt_status_reg(UIC_ISR_MS);
        host.rd(UIC_OFF_MSR, rv);
        interrupt_status_reg(UIC_ISR_SC);
        interrupt_status_reg(UIC_ISR_NONE);
        host.wr(UIC_OFF_IER, 8'hA7);
        @(posedge i_clk_sys) i_cts_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        interrupt_status_reg(UIC_ISR_FC);
        host.rd(UIC_OFF_MSR, rv);
        @(posedge i_clk_sys) i_xoff_rcvd <= 1'b1;
        @(posedge i_clk_sys) i_xoff_rcvd <= 1'b0;
        interrupt_status_reg(UIC_ISR_SC);
        interrupt_status_reg(UIC_ISR_SC);
        @(posedge i_clk_sys) i_xon_rcvd <= 1'b1;
        @(posedge i_clk_sys) i_xon_rcvd <= 1'b0;
        interrupt_status_reg(UIC_ISR_NONE);
        host.wr(UIC_OFF_IER, 8'h02);
        @(posedge i_clk_sys) i_tx_empty <= 1'b0;
        @(posedge i_clk_sys) i_tx_empty <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk("irq tx", 8'(o_irq), 8'h01);
        host.wr(UIC_OFF_DATA, lv);
        repeat (2) @(posedge i_clk_sys);
        chk("irq clr", 8'(o_irq), 8'h00);
        $display("Test interrupt done");
        results();
    end
endmodule
`default_nettype wire

// File: test/uic_host.sv
// Host model driving the register port of the uart control block
`timescale 1ns/1ps
`default_nettype none
module uic_host
(
    input wire logic i_clk_sys,
    output logic [2:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [7:0] i_rdata
);
    // Idle bus, strobes low from time zero
    initial
    begin
        {o_addr, o_wdata, o_wr, o_rd} = '0;
    end
    // One-cycle write; fields scrambled once taken
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
        @(posedge i_clk_sys);
        {o_addr, o_wdata, o_wr} <= {~a, ~d, 1'b0};
    endtask
    // One-cycle read; data stand only in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        {o_addr, o_rd} <= {a, 1'b1};
        @(posedge i_clk_sys);
        {o_addr, o_rd} <= {~a, 1'b0};
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire
